/* logic/cfoa_core.sv */
// flags register, accumulator and operand addressing sequencer
`timescale 1ns/10ps
module cfoa_core
  import cfoa_pkg::*;
(
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  // instruction issue
  input  wire logic          instr_valid_i,
  input  wire cfoa_instr_t   instr_i,
  input  wire logic          supervisor_i,
  output logic               instr_ready_o,
  output logic               instr_done_o,
  output logic [1:0]         instr_len_o,
  output logic               instr_illegal_o,
  // data space
  output cfoa_mem_req_t      mem_req_o,
  input  wire logic          mem_ack_i,
  input  wire logic [7:0]    mem_rdata_i,
  // interrupts
  input  wire logic          irq_pending_i,
  output logic               irq_take_o,
  // state view
  output logic [7:0]         flags_o,
  output logic [7:0]         acc_o,
  output logic [7:0]         index_o
);

  typedef enum logic [2:0] {
    CFOA_IDLE  = 3'b000,
    CFOA_RD1   = 3'b001,
    CFOA_RD2   = 3'b011,
    CFOA_WR1   = 3'b010,
    CFOA_WR2   = 3'b110,
    CFOA_DONE  = 3'b111
  } cfoa_state_t;

  cfoa_state_t   state;
  cfoa_state_t   next_state;
  cfoa_instr_t   ins;
  logic [7:0]    flags;
  logic [7:0]    acc;
  logic [7:0]    index;
  logic [7:0]    ptr;
  logic [7:0]    data1;
  cfoa_mem_req_t req;
  logic          done;
  logic [1:0]    len;
  logic          illegal;
  logic          irq_take;

  // issue-time decode
  wire instr_take   = instr_valid_i && (state == CFOA_IDLE);
  wire dirdir_bad   = (instr_i.mode == CFOA_DST_DIRDIR) && (instr_i.op != CFOA_OP_MOV);
  wire ind_bad      = ((instr_i.mode == CFOA_SRC_IND_POST) ||
                       (instr_i.mode == CFOA_DST_IND_POST)) && (instr_i.op != CFOA_OP_MOV);
  wire flags_bad    = (instr_i.mode == CFOA_FLAGS_LOGIC) &&
                      !((instr_i.op == CFOA_OP_AND) || (instr_i.op == CFOA_OP_OR) ||
                        (instr_i.op == CFOA_OP_XOR));
  wire issue_bad    = dirdir_bad || ind_bad || flags_bad;
  wire [1:0] issue_len = (instr_i.mode == CFOA_DST_DIRDIR) ? LEN_THREE : LEN_TWO;

  // operand selection
  wire [7:0] opc_reg  = ins.use_index ? index : acc;
  wire [7:0] src_addr = (ins.mode == CFOA_SRC_INDEXED) ?
                        cfoa_wrap_add(index, ins.operand1) : ins.operand1;
  wire [7:0] ptr_next = cfoa_wrap_add(ptr, 8'h01);
  wire       bank     = flags[FLAG_BANK_BIT];

  // memory value straight off the bus on the acknowledging edge, else as captured
  wire [7:0] mem_val = (state == CFOA_RD1 && mem_ack_i) ? mem_rdata_i : data1;
  wire [7:0] alu_b   = (ins.mode == CFOA_FLAGS_LOGIC) ? ins.operand1 :
                       (ins.mode == CFOA_DST_DIRECT) ? opc_reg : mem_val;
  wire [7:0] alu_a   = (ins.mode == CFOA_FLAGS_LOGIC) ? flags :
                       (ins.mode == CFOA_DST_DIRECT) ? mem_val : opc_reg;
  wire [7:0] alu_res;
  wire       alu_carry;
  wire       alu_zero;

  cfoa_alu u_alu (
    .op_i    (ins.op),
    .a_i     (alu_a),
    .b_i     (alu_b),
    .res_o   (alu_res),
    .carry_o (alu_carry),
    .zero_o  (alu_zero)
  );

  // flag update: logical and arithmetic ops touch carry and zero
  wire arith_op = (ins.op != CFOA_OP_MOV);
  wire [7:0] flags_logic = (alu_res & FLAGS_WR_MASK) | (flags & ~FLAGS_WR_MASK);
  wire [7:0] flags_cz    = {flags[7:3], alu_carry, alu_zero, flags[0]};
  wire [7:0] flags_done  = (ins.mode == CFOA_FLAGS_LOGIC) ? flags_logic :
                           arith_op ? flags_cz : flags;
  wire [7:0] flags_view  = {flags[7:4], supervisor_i, flags[2:0]};

  // sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      CFOA_IDLE: begin
        if (instr_take && !issue_bad) begin
          next_state = (instr_i.mode == CFOA_FLAGS_LOGIC) ? CFOA_DONE : CFOA_RD1;
        end
      end
      CFOA_RD1: begin
        if (mem_ack_i) begin
          next_state = (ins.mode == CFOA_SRC_IND_POST) ? CFOA_RD2 :
                       (ins.mode == CFOA_SRC_DIRECT || ins.mode == CFOA_SRC_INDEXED) ?
                       CFOA_DONE : CFOA_WR1;
        end
      end
      CFOA_RD2: begin
        if (mem_ack_i) begin
          next_state = CFOA_WR1;
        end
      end
      CFOA_WR1: begin
        if (mem_ack_i) begin
          next_state = (ins.mode == CFOA_DST_IND_POST) ? CFOA_WR2 : CFOA_DONE;
        end
      end
      CFOA_WR2: begin
        if (mem_ack_i) begin
          next_state = CFOA_DONE;
        end
      end
      CFOA_DONE: begin
        next_state = CFOA_IDLE;
      end
      default: begin
        next_state = CFOA_IDLE;
      end
    endcase
  end

  // request builder for the state being entered or held
  cfoa_mem_req_t next_req;
  always_comb begin
    next_req           = '0;
    next_req.bank      = bank;
    unique case (next_state)
      CFOA_RD1: begin
        next_req.valid     = 1'b1;
        next_req.reg_space = (state == CFOA_IDLE) ? instr_i.reg_space : ins.reg_space;
        next_req.addr      = (state == CFOA_IDLE) ?
                             ((instr_i.mode == CFOA_SRC_INDEXED) ?
                              cfoa_wrap_add(index, instr_i.operand1) : instr_i.operand1) :
                             src_addr;
        if ((state == CFOA_IDLE) ? (instr_i.mode == CFOA_DST_DIRDIR) :
                                   (ins.mode == CFOA_DST_DIRDIR)) begin
          next_req.reg_space = 1'b0;
          next_req.addr      = (state == CFOA_IDLE) ? instr_i.operand2 : ins.operand2;
        end
      end
      CFOA_RD2: begin
        next_req.valid = 1'b1;
        next_req.addr  = (state == CFOA_RD1) ? mem_rdata_i : ptr;
      end
      default: begin
        next_req = '0;
      end
    endcase
    next_req.bank = bank;
  end

  // the memory port registered; bank applies only to register space
  wire route_bank = req.reg_space & bank;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= CFOA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      req      <= '0;
      ins      <= '0;
      data1    <= 8'h00;
      ptr      <= 8'h00;
      done     <= 1'b0;
      len      <= 2'h0;
      illegal  <= 1'b0;
    end else begin
      done    <= (next_state == CFOA_DONE);
      illegal <= instr_take && issue_bad;
      if (instr_take) begin
        ins <= instr_i;
        len <= issue_len;
      end
      if (state == CFOA_RD1 && mem_ack_i) begin
        data1 <= mem_rdata_i;
        ptr   <= mem_rdata_i;
      end
      if (state == CFOA_RD2 && mem_ack_i && ins.mode == CFOA_SRC_IND_POST) begin
        data1 <= mem_rdata_i;
      end
      if (!((state == CFOA_WR1 || state == CFOA_WR2) && !mem_ack_i)) begin
        req <= next_req;
      end
      if (next_state == CFOA_WR1 && state != CFOA_WR1) begin
        req.valid <= 1'b1;
        req.write <= 1'b1;
        req.bank  <= bank;
        if (ins.mode == CFOA_DST_DIRECT) begin
          req.reg_space <= ins.reg_space;
          req.addr      <= ins.operand1;
          req.wdata     <= alu_res;
        end else if (ins.mode == CFOA_DST_DIRDIR) begin
          req.reg_space <= 1'b0;
          req.addr      <= ins.operand1;
          req.wdata     <= mem_val;
        end else if (ins.mode == CFOA_DST_IND_POST) begin
          req.reg_space <= 1'b0;
          req.addr      <= mem_val;
          req.wdata     <= acc;
        end else begin
          req.reg_space <= 1'b0;
          req.addr      <= ins.operand1;
          req.wdata     <= ptr_next;
        end
      end
      if (next_state == CFOA_WR2 && state != CFOA_WR2) begin
        req.valid     <= 1'b1;
        req.write     <= 1'b1;
        req.reg_space <= 1'b0;
        req.addr      <= ins.operand1;
        req.wdata     <= ptr_next;
      end
    end
  end

  // architectural registers
  wire src_mode = (ins.mode == CFOA_SRC_DIRECT) || (ins.mode == CFOA_SRC_INDEXED);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags <= FLAGS_RESET;
      acc   <= ACC_RESET;
      index <= INDEX_RESET;
    end else if (state == CFOA_DONE) begin
      flags <= flags_done;
      if (src_mode && ins.use_index) begin
        index <= alu_res;
      end else if (src_mode) begin
        acc <= alu_res;
      end else if (ins.mode == CFOA_SRC_IND_POST) begin
        acc <= data1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= irq_pending_i && flags[FLAG_GIE_BIT] && (state == CFOA_IDLE);
    end
  end

  assign instr_ready_o   = (state == CFOA_IDLE);
  assign instr_done_o    = done;
  assign instr_len_o     = len;
  assign instr_illegal_o = illegal;
  assign irq_take_o      = irq_take;
  assign flags_o         = flags_view;
  assign acc_o           = acc;
  assign index_o         = index;
  always_comb begin
    mem_req_o      = req;
    mem_req_o.bank = route_bank;
  end

  // checks
  gie_gate_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    irq_take_o |-> $past(flags[FLAG_GIE_BIT]))
    else $error("interrupt taken with enable clear");
  flags_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state != CFOA_DONE) |=> $stable(flags))
    else $error("flags changed outside completion");
  flags_mov_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == CFOA_DONE && ins.op == CFOA_OP_MOV) |=> $stable(flags))
    else $error("move altered flags");
  bank_route_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mem_req_o.valid && !mem_req_o.reg_space) |-> !mem_req_o.bank)
    else $error("ram access carried bank");
  super_view_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    flags_o[FLAG_SUPER_BIT] == supervisor_i)
    else $error("supervisor bit mismatch");
  dirdir_len_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (instr_take && !issue_bad && instr_i.mode == CFOA_DST_DIRDIR)
      |=> len == LEN_THREE)
    else $error("direct-direct length wrong");
  zero_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == CFOA_DONE && src_mode && ins.op != CFOA_OP_MOV)
      |=> flags[FLAG_ZERO_BIT] == (acc == 8'h00 && !ins.use_index ||
                                   index == 8'h00 && ins.use_index))
    else $error("zero flag wrong");
  bad_refused_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (instr_take && issue_bad) |=> (state == CFOA_IDLE) && instr_illegal_o)
    else $error("illegal mode accepted");
  ptr_inc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == CFOA_WR2 && mem_req_o.valid) |-> mem_req_o.wdata == ptr_next)
    else $error("pointer not incremented");
  req_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mem_req_o.valid && !mem_ack_i) |=> $stable(mem_req_o))
    else $error("request changed before acknowledge");

  cover_src_c: cover property (@(posedge clock_i) state == CFOA_DONE && src_mode);
  cover_ind_c: cover property (@(posedge clock_i) state == CFOA_WR2 && mem_ack_i);
  cover_dd_c:  cover property (@(posedge clock_i) state == CFOA_DONE &&
                               ins.mode == CFOA_DST_DIRDIR);
  cover_irq_c: cover property (@(posedge clock_i) irq_take_o);

endmodule : cfoa_core

/* logic/cfoa_pkg.sv */
// constants and types shared by the flags and operand addressing block
package cfoa_pkg;

  localparam int unsigned DATA_W = 8;

  // condition_flags field positions and reset
  localparam int unsigned FLAG_BANK_BIT  = 4;
  localparam int unsigned FLAG_SUPER_BIT = 3;
  localparam int unsigned FLAG_CARRY_BIT = 2;
  localparam int unsigned FLAG_ZERO_BIT  = 1;
  localparam int unsigned FLAG_GIE_BIT   = 0;
  localparam logic [7:0]  FLAGS_RESET    = 8'h02;
  localparam logic [7:0]  FLAGS_WR_MASK  = 8'h17;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [7:0]  INDEX_RESET    = 8'h00;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // operand addressing modes
  typedef enum logic [2:0] {
    CFOA_SRC_DIRECT   = 3'h0,
    CFOA_SRC_INDEXED  = 3'h1,
    CFOA_DST_DIRECT   = 3'h2,
    CFOA_DST_DIRDIR   = 3'h3,
    CFOA_SRC_IND_POST = 3'h4,
    CFOA_DST_IND_POST = 3'h5,
    CFOA_FLAGS_LOGIC  = 3'h6
  } cfoa_mode_t;

  // operations
  typedef enum logic [2:0] {
    CFOA_OP_MOV = 3'h0,
    CFOA_OP_ADD = 3'h1,
    CFOA_OP_SUB = 3'h2,
    CFOA_OP_AND = 3'h3,
    CFOA_OP_OR  = 3'h4,
    CFOA_OP_XOR = 3'h5
  } cfoa_op_t;

  // decoded instruction handed in by the fetch logic
  typedef struct packed {
    cfoa_mode_t  mode;
    cfoa_op_t    op;
    logic        use_index;  // opcode names index register, else accumulator
    logic        reg_space;  // operand lies in register space, else RAM
    logic [7:0]  operand1;
    logic [7:0]  operand2;
  } cfoa_instr_t;

  // one data-space access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        reg_space;
    logic        bank;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } cfoa_mem_req_t;

  // address arithmetic wraps in eight bits
  function automatic logic [7:0] cfoa_wrap_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction : cfoa_wrap_add

endpackage : cfoa_pkg

/* logic/cfoa_alu.sv */
// combinational alu producing result, carry and zero
`timescale 1ns/10ps
module cfoa_alu
  import cfoa_pkg::*;
(
  // operands
  input  wire cfoa_op_t   op_i,
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  // results
  output logic [7:0]      res_o,
  output logic            carry_o,
  output logic            zero_o
);

  wire [8:0] sum_w  = {1'b0, a_i} + {1'b0, b_i};
  wire [8:0] diff_w = {1'b0, a_i} - {1'b0, b_i};

  always_comb begin
    res_o   = b_i;
    carry_o = 1'b0;
    unique case (op_i)
      CFOA_OP_MOV: begin
        res_o = b_i;
      end
      CFOA_OP_ADD: begin
        res_o   = sum_w[7:0];
        carry_o = sum_w[8];
      end
      CFOA_OP_SUB: begin
        res_o   = diff_w[7:0];
        carry_o = diff_w[8];
      end
      CFOA_OP_AND: begin
        res_o = a_i & b_i;
      end
      CFOA_OP_OR: begin
        res_o = a_i | b_i;
      end
      CFOA_OP_XOR: begin
        res_o = a_i ^ b_i;
      end
      default: begin
        res_o = b_i;
      end
    endcase
  end

  assign zero_o = (res_o == 8'h00);

endmodule : cfoa_alu

/* testbench/cfoa_mem_model.sv */
// behavioural ram and two register banks answering the core's data requests
`timescale 1ns/10ps
module cfoa_mem_model
  import cfoa_pkg::*;
(
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  // request side
  input  wire cfoa_mem_req_t mem_req_i,
  input  wire logic          slow_i,
  // answer side
  output logic               mem_ack_o,
  output logic [7:0]         mem_rdata_o
);
  logic [7:0] ram [256];
  logic [7:0] rb0 [256];
  logic [7:0] rb1 [256];
  logic [2:0] wait_q;

  // only register space follows the bank bit
  wire logic [7:0] bank_rd_w = mem_req_i.bank ? rb1[mem_req_i.addr] : rb0[mem_req_i.addr];
  wire logic [7:0] rd_w      = mem_req_i.reg_space ? bank_rd_w : ram[mem_req_i.addr];
  wire logic       go_w      = mem_req_i.valid && !mem_ack_o && (wait_q == 3'h3 || !slow_i);

  // plain always so the bench may preload the arrays
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 8'h00;
      wait_q      <= 3'h0;
    end else if (go_w) begin
      mem_ack_o   <= 1'b1;
      mem_rdata_o <= rd_w;
      wait_q      <= 3'h0;
      if (mem_req_i.write && !mem_req_i.reg_space) ram[mem_req_i.addr] <= mem_req_i.wdata;
      if (mem_req_i.write && mem_req_i.reg_space && mem_req_i.bank) rb1[mem_req_i.addr] <= mem_req_i.wdata;
      if (mem_req_i.write && mem_req_i.reg_space && !mem_req_i.bank) rb0[mem_req_i.addr] <= mem_req_i.wdata;
    end else begin
      mem_ack_o   <= 1'b0;
      // stale data must not look valid between answers
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i.valid && !mem_ack_o) wait_q <= wait_q + 3'h1;
    end
  end
endmodule : cfoa_mem_model

/* testbench/cpu_flags_and_operand_addressing_test.sv */
// self-checking bench for the flags and operand addressing core
`timescale 1ns/10ps
module cpu_flags_and_operand_addressing_test
  import cfoa_pkg::*;
;
  logic          clock_i       = 1'b0;
  logic          sys_rst_i     = 1'b1;
  logic          instr_valid_i = 1'b0;
  cfoa_instr_t   instr_i       = '0;
  logic          supervisor_i  = 1'b0;
  logic          irq_pending_i = 1'b0;
  logic          slow          = 1'b0;
  logic          ill           = 1'b0;
  logic          took          = 1'b0;
  logic          instr_ready_o, instr_done_o, instr_illegal_o, irq_take_o, mem_ack_i;
  logic [1:0]    instr_len_o;
  cfoa_mem_req_t mem_req_o;
  logic [7:0]    mem_rdata_i, flags_o, acc_o, index_o;
  int            n_fail        = 0;
  int            checked       = 0;

  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (irq_take_o === 1'b1) took <= 1'b1;

  cfoa_core dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .supervisor_i(supervisor_i), .instr_ready_o(instr_ready_o),
    .instr_done_o(instr_done_o), .instr_len_o(instr_len_o),
    .instr_illegal_o(instr_illegal_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .irq_pending_i(irq_pending_i), .irq_take_o(irq_take_o),
    .flags_o(flags_o), .acc_o(acc_o), .index_o(index_o));

  cfoa_mem_model mem (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_o), .slow_i(slow),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic run(input cfoa_mode_t md, input cfoa_op_t op, input logic ix,
                     input logic rs, input logic [7:0] a, input logic [7:0] b);
    int i;
    ill = 1'b0;
    i   = 0;
    // ready read off the edge, so the request meets exactly one taking edge
    while (instr_ready_o !== 1'b1 && i < 20) begin
      @(posedge clock_i);
      #1;
      i++;
    end
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i       <= '{md, op, ix, rs, a, b};
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    // illegal may show right after the taking edge
    for (i = 0; i < 40; i++) begin
      #1;
      if (instr_illegal_o === 1'b1) ill = 1'b1;
      if (instr_done_o === 1'b1 || ill) break;
      @(posedge clock_i);
    end
    if (i == 40) begin
      n_fail++;
      $display("mismatch at %0t: no completion", $time);
    end
    @(posedge clock_i);
    #1;
  endtask : run

  initial begin
    #200000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    mem.ram[8'h10] = 8'h5A;
    mem.rb1[8'h08] = 8'hF0;
    mem.rb0[8'h08] = 8'h33;
    mem.ram[8'h08] = 8'hD0;
    mem.ram[8'h09] = 8'h03;
    mem.ram[8'h0A] = 8'h02;
    mem.ram[8'h50] = 8'hFF;
    mem.ram[8'hFF] = 8'h77;
    mem.ram[8'h30] = 8'h10;
    mem.ram[8'h51] = 8'h60;
    mem.ram[8'h41] = 8'hA5;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(flags_o, FLAGS_RESET);
    chk(acc_o, ACC_RESET);
    @(posedge clock_i);
    supervisor_i <= 1'b1;
    #1;
    chk(flags_o, 8'h0A);
    @(posedge clock_i);
    supervisor_i <= 1'b0;
    run(CFOA_FLAGS_LOGIC, CFOA_OP_OR, 1'b0, 1'b0, 8'h10, 8'h00);
    chk(flags_o, 8'h12);
    run(CFOA_FLAGS_LOGIC, CFOA_OP_ADD, 1'b0, 1'b0, 8'h01, 8'h00);
    chk({7'h0, ill}, 8'h01);
    chk(flags_o, 8'h12);
    run(CFOA_SRC_DIRECT, CFOA_OP_MOV, 1'b1, 1'b1, 8'h08, 8'h00);
    chk(index_o, 8'hF0);
    run(CFOA_SRC_INDEXED, CFOA_OP_MOV, 1'b0, 1'b0, 8'h20, 8'h00);
    chk(acc_o, 8'h5A);
    run(CFOA_FLAGS_LOGIC, CFOA_OP_XOR, 1'b0, 1'b0, 8'h10, 8'h00);
    chk(flags_o, 8'h02);
    run(CFOA_SRC_DIRECT, CFOA_OP_MOV, 1'b0, 1'b1, 8'h08, 8'h00);
    chk(acc_o, 8'h33);
    chk({6'h0, instr_len_o}, {6'h0, LEN_TWO});
    run(CFOA_SRC_DIRECT, CFOA_OP_ADD, 1'b0, 1'b0, 8'h08, 8'h00);
    chk(acc_o, 8'h03);
    chk(flags_o, 8'h04);
    @(posedge clock_i);
    slow <= 1'b1;
    run(CFOA_SRC_DIRECT, CFOA_OP_SUB, 1'b0, 1'b0, 8'h09, 8'h00);
    chk(acc_o, 8'h00);
    chk(flags_o, 8'h02);
    run(CFOA_SRC_DIRECT, CFOA_OP_SUB, 1'b0, 1'b0, 8'h09, 8'h00);
    chk(acc_o, 8'hFD);
    chk(flags_o, 8'h04);
    run(CFOA_SRC_DIRECT, CFOA_OP_AND, 1'b0, 1'b0, 8'h0A, 8'h00);
    chk(flags_o, 8'h02);
    run(CFOA_SRC_IND_POST, CFOA_OP_MOV, 1'b0, 1'b0, 8'h50, 8'h00);
    chk(acc_o, 8'h77);
    chk(mem.ram[8'h50], 8'h00);
    run(CFOA_DST_DIRECT, CFOA_OP_ADD, 1'b0, 1'b0, 8'h30, 8'h00);
    chk(mem.ram[8'h30], 8'h87);
    chk(acc_o, 8'h77);
    chk(flags_o, 8'h00);
    run(CFOA_DST_DIRECT, CFOA_OP_MOV, 1'b1, 1'b0, 8'h31, 8'h00);
    chk(mem.ram[8'h31], 8'hF0);
    run(CFOA_DST_IND_POST, CFOA_OP_MOV, 1'b0, 1'b0, 8'h51, 8'h00);
    chk(mem.ram[8'h60], 8'h77);
    chk(mem.ram[8'h51], 8'h61);
    @(posedge clock_i);
    slow <= 1'b0;
    run(CFOA_DST_DIRDIR, CFOA_OP_MOV, 1'b0, 1'b0, 8'h40, 8'h41);
    chk(mem.ram[8'h40], 8'hA5);
    chk({6'h0, instr_len_o}, {6'h0, LEN_THREE});
    mem.ram[8'h41] = 8'h11;
    run(CFOA_DST_DIRDIR, CFOA_OP_ADD, 1'b0, 1'b0, 8'h40, 8'h41);
    chk({7'h0, ill}, 8'h01);
    chk(mem.ram[8'h40], 8'hA5);
    run(CFOA_SRC_IND_POST, CFOA_OP_OR, 1'b0, 1'b0, 8'h50, 8'h00);
    chk({7'h0, ill}, 8'h01);
    chk(acc_o, 8'h77);
    // interrupt held off while the enable bit is clear
    took = 1'b0;
    @(posedge clock_i);
    irq_pending_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    #1;
    chk({7'h0, took}, 8'h00);
    run(CFOA_FLAGS_LOGIC, CFOA_OP_OR, 1'b0, 1'b0, 8'h01, 8'h00);
    repeat (3) @(posedge clock_i);
    #1;
    chk({7'h0, took}, 8'h01);
    @(posedge clock_i);
    irq_pending_i <= 1'b0;
    sys_rst_i     <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i     <= 1'b0;
    #1;
    chk(flags_o, FLAGS_RESET);
    chk(acc_o, ACC_RESET);
    chk(index_o, INDEX_RESET);
    summarize();
  end
endmodule : cpu_flags_and_operand_addressing_test
